// ---- rtl/local_bus_defs.vh ----
// constants for the local bus address and arbitration port
`ifndef LOCAL_BUS_DEFS_VH
`define LOCAL_BUS_DEFS_VH
`define ADDR_W 32
`define REG_OFFSET_W 12
`define ROLE_MASTER_BURST 1'b0
`define ROLE_MASTER_SIZE 1'b0
`define PIN_IDLE_N 1'b1
`define FLAG_RST 1'b0
`define ADDR_RST 32'h00000000
`define OFFSET_RST 12'h000
`endif

// ---- rtl/local_bus_addr_arbitration.v ----
// local bus address port, bus arbitration and reset role strapping
`timescale 1ns/10ps
`include "local_bus_defs.vh"
// Operation
// - drive address as master, input as slave
// - slave captures address when transfer start sampled
// - master address launched after rising edge
// - register offset from low twelve bits
// - owner holds bus busy asserted
// - master asserts bus busy from rising edge
// - negate bus busy before releasing line
// - sample bus busy on rising edges
// - optional asynchronous arbitration sampling mode
// - burst pin used only at reset
// - role chosen from burst and size pins
// - request bus on rising edges
// - sample bus grant on rising edges
module local_bus_addr_arbitration (
  input wire clock_i,
  input wire resetn_i,
  input wire async_arb_i,
  input wire burst_in_progress_n_i,
  input wire transfer_size_hi_i,
  input wire transfer_start_n_i,
  input wire [31:0] addr_i,
  output reg [31:0] addr_o,
  output reg addr_oe_o,
  input wire bus_grant_n_i,
  input wire bus_busy_n_i,
  output reg bus_busy_n_o,
  output reg bus_busy_n_oe_o,
  output reg bus_request_n_o,
  input wire xfer_req_i,
  input wire [31:0] xfer_addr_i,
  input wire xfer_done_i,
  output reg owner_o,
  output reg master_role_o,
  output reg slave_hit_o,
  output reg [31:0] slave_addr_o,
  output reg [11:0] slave_offset_o
);
  // ownership states; the slave state holds until the next reset
  localparam ST_IDLE = 3'h0;
  localparam ST_REQUEST = 3'h1;
  localparam ST_OWN = 3'h2;
  localparam ST_NEGATE = 3'h3;
  localparam ST_SLAVE = 3'h4;
  // slots of the two arbitration inputs in the filter
  localparam ARB_GRANT = 0;
  localparam ARB_BUSY = 1;
  localparam ARB_LINES = 2;

  reg [2:0] state;
  reg [2:0] next_state;
  reg strap_done;
  wire [ARB_LINES-1:0] arb_pin;
  wire [ARB_LINES-1:0] arb_filt;
  wire grant_now;
  wire busy_now;
  wire slave_take;
  genvar arb_idx;

  // the state that owns the bus and drives address and busy low
  function owns_bus;
    input [2:0] st;
    begin
      owns_bus = (st == ST_OWN);
    end
  endfunction

  // busy stays driven one cycle longer than ownership
  function drives_busy;
    input [2:0] st;
    begin
      drives_busy = owns_bus(st) || (st == ST_NEGATE);
    end
  endfunction

  // slave address qualifier
  function start_seen;
    input [2:0] st;
    input start_n;
    begin
      start_seen = (st == ST_SLAVE) && !start_n;
    end
  endfunction

  assign arb_pin[ARB_GRANT] = bus_grant_n_i;
  assign arb_pin[ARB_BUSY] = bus_busy_n_i;

  // async mode filters the arbitration lines; a level counts once the last two stages agree
  generate
    for (arb_idx = 0; arb_idx < ARB_LINES; arb_idx = arb_idx + 1)
    begin : g_arb_filter
      reg stage1;
      reg stage2;
      reg stage3;
      reg level;
      always @(posedge clock_i or negedge resetn_i)
      begin
        if (!resetn_i)
        begin
          stage1 <= `PIN_IDLE_N;
          stage2 <= `PIN_IDLE_N;
          stage3 <= `PIN_IDLE_N;
          level <= `PIN_IDLE_N;
        end
        else
        begin
          stage1 <= arb_pin[arb_idx];
          stage2 <= stage1;
          stage3 <= stage2;
          if (stage2 == stage3)
            level <= stage3;
        end
      end
      assign arb_filt[arb_idx] = level;
    end
  endgenerate

  // synchronous mode uses the pins as sampled at this edge; the filter adds four edges of latency
  assign grant_now = async_arb_i ? arb_filt[ARB_GRANT] : bus_grant_n_i;
  assign busy_now = async_arb_i ? arb_filt[ARB_BUSY] : bus_busy_n_i;
  assign slave_take = start_seen(state, transfer_start_n_i);

  // strap caught at first edge after reset release; burst pin ignored afterwards
  always @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      strap_done <= `FLAG_RST;
      master_role_o <= `FLAG_RST;
    end
    else if (!strap_done)
    begin
      strap_done <= 1'b1;
      master_role_o <= (burst_in_progress_n_i == `ROLE_MASTER_BURST) &&
                       (transfer_size_hi_i == `ROLE_MASTER_SIZE);
    end
  end

  // request stays out until the grant and an idle busy line are seen together
  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        if (strap_done && !master_role_o)
          next_state = ST_SLAVE;
        else if (strap_done && xfer_req_i)
          next_state = ST_REQUEST;
      end
      ST_REQUEST:
      begin
        if (!grant_now && busy_now)
          next_state = ST_OWN;
      end
      ST_OWN:
      begin
        if (xfer_done_i)
          next_state = ST_NEGATE;
      end
      ST_NEGATE:
      begin
        next_state = ST_IDLE;
      end
      ST_SLAVE:
      begin
        next_state = ST_SLAVE;
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state <= ST_IDLE;
      bus_request_n_o <= `PIN_IDLE_N;
      bus_busy_n_o <= `PIN_IDLE_N;
      bus_busy_n_oe_o <= `FLAG_RST;
      addr_o <= `ADDR_RST;
      addr_oe_o <= `FLAG_RST;
      owner_o <= `FLAG_RST;
    end
    else
    begin
      state <= next_state;
      bus_request_n_o <= !(next_state == ST_REQUEST);
      owner_o <= owns_bus(next_state);
      // one cycle driven high before release avoids a slow pull-up edge
      bus_busy_n_o <= !owns_bus(next_state);
      bus_busy_n_oe_o <= drives_busy(next_state);
      addr_oe_o <= owns_bus(next_state);
      if ((state == ST_REQUEST) && owns_bus(next_state))
        addr_o <= xfer_addr_i;
    end
  end

  // slave capture only on edge with transfer start asserted
  always @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      slave_hit_o <= `FLAG_RST;
      slave_addr_o <= `ADDR_RST;
      slave_offset_o <= `OFFSET_RST;
    end
    else
    begin
      slave_hit_o <= slave_take;
      if (slave_take)
      begin
        slave_addr_o <= addr_i;
        slave_offset_o <= addr_i[`REG_OFFSET_W-1:0];
      end
    end
  end
endmodule

// ---- verif/local_bus_props.sv ----
// checker for the local bus port
`timescale 1ns/10ps
module local_bus_props (
  input wire clock_i,
  input wire resetn_i,
  input wire async_arb_i,
  input wire transfer_start_n_i,
  input wire addr_oe_o,
  input wire bus_grant_n_i,
  input wire bus_busy_n_i,
  input wire bus_busy_n_o,
  input wire bus_busy_n_oe_o,
  input wire bus_request_n_o,
  input wire owner_o,
  input wire master_role_o,
  input wire slave_hit_o,
  input wire [31:0] addr_i,
  input wire [31:0] addr_o,
  input wire [31:0] xfer_addr_i,
  input wire [31:0] slave_addr_o,
  input wire [11:0] slave_offset_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  a_own_busy: assert property (owner_o |-> !bus_busy_n_o && bus_busy_n_oe_o && addr_oe_o) else $error("own");
  a_busy_rel: assert property ($fell(owner_o) |-> bus_busy_n_o && bus_busy_n_oe_o ##1 !bus_busy_n_oe_o)
    else $error("rel");
  a_grant_take: assert property (!async_arb_i && !owner_o && !bus_request_n_o && !bus_grant_n_i && bus_busy_n_i
    |=> owner_o) else $error("take");
  a_own_cause: assert property (!async_arb_i && $rose(owner_o) |-> $past(!bus_grant_n_i && bus_busy_n_i))
    else $error("cause");
  a_addr_out: assert property ($rose(addr_oe_o) |-> addr_o == xfer_addr_i) else $error("addr");
  a_slave_cap: assert property (!master_role_o && !transfer_start_n_i |=> slave_hit_o
    && slave_addr_o == $past(addr_i)) else $error("cap");
  a_offset_low: assert property (slave_hit_o |-> slave_offset_o == slave_addr_o[11:0]) else $error("off");
  a_slave_quiet: assert property (!master_role_o |-> bus_request_n_o && !addr_oe_o) else $error("quiet");
  a_req_drop: assert property ($rose(owner_o) |-> bus_request_n_o) else $error("req");
  c_own: cover property (async_arb_i && $rose(owner_o));
  c_hit: cover property (slave_hit_o);
  c_rel: cover property ($fell(owner_o));
  c_wait: cover property (!bus_request_n_o && !bus_grant_n_i && !bus_busy_n_i);
endmodule
bind local_bus_addr_arbitration local_bus_props props (.*);

// ---- verif/bus_arbiter_model.sv ----
// arbiter and previous bus owner on the far side
`timescale 1ns/10ps
module bus_arbiter_model (
  input wire clock_i,
  input wire bus_request_n_i,
  input wire hold_i,
  output reg bus_grant_n_o,
  output reg bus_busy_n_o
);
  initial bus_grant_n_o = 1'b1;
  initial bus_busy_n_o = 1'b1;
  always @(posedge clock_i)
  begin
    bus_grant_n_o <= bus_request_n_i;
    bus_busy_n_o <= !hold_i;
  end
endmodule

// ---- verif/local_bus_addr_arbitration_tb_top.sv ----
// bench for the local bus port
`timescale 1ns/10ps
module local_bus_addr_arbitration_tb_top;
  reg clk = 1'b0, rst_n = 1'b0, strap = 1'b0, start_n = 1'b1, req = 1'b0, done = 1'b0, hold = 1'b0, asy = 1'b0;
  reg [31:0] a_in = 32'h0, xa = 32'h0;
  wire [31:0] a_out, s_addr;
  wire [11:0] off;
  wire a_oe, busy_n, busy_oe, req_n, gnt_n, far_busy_n, own, role, hit;
  integer mismatches = 0, checked = 0, i;
  always #2 clk = !clk;
  local_bus_addr_arbitration dut (.clock_i(clk), .resetn_i(rst_n), .async_arb_i(asy),
    .burst_in_progress_n_i(strap), .transfer_size_hi_i(strap), .transfer_start_n_i(start_n), .addr_i(a_in),
    .addr_o(a_out), .addr_oe_o(a_oe), .bus_grant_n_i(gnt_n), .bus_busy_n_i(busy_oe ? busy_n : far_busy_n),
    .bus_busy_n_o(busy_n), .bus_busy_n_oe_o(busy_oe), .bus_request_n_o(req_n), .xfer_req_i(req),
    .xfer_addr_i(xa), .xfer_done_i(done), .owner_o(own), .master_role_o(role), .slave_hit_o(hit),
    .slave_addr_o(s_addr), .slave_offset_o(off));
  bus_arbiter_model arb (.clock_i(clk), .bus_request_n_i(req_n), .hold_i(hold), .bus_grant_n_o(gnt_n),
    .bus_busy_n_o(far_busy_n));
  task chk(input [35:0] seen, input [35:0] exp, input [63:0] what);
  begin
    checked = checked + 1;
    if (seen !== exp)
    begin
      mismatches = mismatches + 1;
      $display("Error %0s exp %h seen %h", what, exp, seen);
    end
  end
  endtask
  task stop_test;
  begin
    if (mismatches == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask
  task boot(input s);
  begin
    rst_n = 1'b0;
    strap = s;
    repeat (4) @(negedge clk);
    chk({own, busy_oe, a_oe, req_n, hit}, 5'h02, "reset");
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    chk(role, !s, "role");
    // the strap pins change after reset; the role must not follow
    strap = !s;
    @(negedge clk);
    chk(role, !s, "keep");
  end
  endtask
  // h keeps the old owner on the bus so the grant alone must not win
  task master(input h);
  begin
    hold = h;
    xa = 32'h1234_5abc;
    req = 1'b1;
    @(negedge clk) req = 1'b0;
    repeat (6) @(negedge clk);
    chk({own, req_n} & {2{h}}, 2'h0, "early");
    hold = 1'b0;
    for (i = 0; i < 20 && own !== 1'b1; i = i + 1) @(negedge clk);
    chk({busy_n, busy_oe, a_oe, a_out}, {3'h3, xa}, "busy");
    chk(req_n, 1'b1, "reqoff");
    done = 1'b1;
    @(negedge clk) done = 1'b0;
    chk({own, busy_n, busy_oe, a_oe}, 4'h6, "release");
    @(negedge clk);
    chk(busy_oe, 1'b0, "float");
  end
  endtask
  task slave;
  begin
    boot(1'b1);
    a_in = 32'hcafe_f123;
    start_n = 1'b0;
    @(negedge clk) start_n = 1'b1;
    a_in = ~a_in;
    chk({hit, s_addr}, {1'b1, 32'hcafe_f123}, "capture");
    chk(off, 12'h123, "offset");
    @(negedge clk);
    chk({hit, s_addr}, {1'b0, 32'hcafe_f123}, "hold");
    req = 1'b1;
    repeat (3) @(negedge clk);
    chk({req_n, a_oe}, 2'h2, "noreq");
    req = 1'b0;
  end
  endtask
  initial
  begin
    #4000;
    mismatches = mismatches + 1;
    stop_test;
  end
  initial
  begin
    boot(0);
    master(1);
    asy = 1;
    master(0);
    asy = 0;
    slave;
    stop_test;
  end
endmodule
